//--- shared/cehs_pkg.sv
/*
 * Package for the compute-engine signalling block: timing counts,
 * result-area offsets, gain scaling and the carrier structs.
 * Assumes one 100 MHz clock shared by the engine and the controller.
 */
// Operation
// - the engine takes all set-up only from configuration words and RAM shared with the controller.
// - the engine drives two busy outputs, processing and result transfer, to controller interrupts.
// - the processing flag is high while the engine works on sample data.
// - the processing flag pulses exactly once per input multiplexer cycle.
// - the transfer flag is high while results are written to the RAM output area.
// - a transfer happens once per interval of sum-cycle count times pre-sample count samples.
// - each interrupt is raised on the falling edge of its busy flag only.
// - power outputs are scaled by the gain word, 16385 meaning no temperature deviation.
// - the temperature result is the sum of two consecutive raw readings.
package cehs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROC_STEPS    = 3;
    localparam int unsigned XFER_WORDS    = 2;

    localparam logic [15:0] GAIN_NOMINAL  = 16'h4001;
    localparam int unsigned GAIN_SHIFT    = 14;

    localparam logic [3:0]  RES_ADDR_POWER = 4'h0;
    localparam logic [3:0]  RES_ADDR_TEMP  = 4'h1;

    typedef struct packed {
        logic [5:0]  sum_cycles;
        logic [1:0]  pre_sample_count;
        logic [15:0] temperature_gain_word;
    } cehs_cfg_t;

    typedef struct packed {
        logic        we;
        logic [3:0]  addr;
        logic [31:0] data;
    } cehs_ram_wr_t;

    typedef enum logic [1:0] {
        P_IDLE  = 2'b00,
        P_MULT  = 2'b01,
        P_SCALE = 2'b10,
        P_ACC   = 2'b11
    } cehs_proc_t;

    typedef enum logic [1:0] {
        X_IDLE  = 2'b00,
        X_POWER = 2'b01,
        X_TEMP  = 2'b10
    } cehs_xfer_t;

endpackage : cehs_pkg

//--- src/cehs_engine.sv
/*
 * Compute-engine side of the engine/controller signalling: per-cycle
 * power pass, interval accumulation, result write-out, busy flags and
 * falling-edge interrupt pulses, temperature result summed over reading pairs.
 * Assumes configuration and samples come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cehs_engine (
    input  wire logic                  clk,           // 100 MHz clock
    input  wire logic                  resetn,        // async reset, low
    input  wire cehs_pkg::cehs_cfg_t   cfg,           // shared config words
    input  wire logic                  mux_start,     // new mux cycle pulse
    input  wire logic signed [15:0]    volt_sample,   // voltage sample
    input  wire logic signed [15:0]    curr_sample,   // current sample
    input  wire logic                  temp_valid,    // raw temp strobe
    input  wire logic [15:0]           temp_raw,      // raw temp reading
    output var  logic                  processing_active,    // busy level
    output var  logic                  result_transfer_flag, // xfer level
    output var  logic                  irq_processing,       // fall pulse
    output var  logic                  irq_transfer,         // fall pulse
    output var  cehs_pkg::cehs_ram_wr_t ram_wr,        // result RAM write
    output var  logic [16:0]           temp_result    // sum of reading pair
);

    cehs_pkg::cehs_proc_t  state;
    cehs_pkg::cehs_proc_t  next_state;
    cehs_pkg::cehs_xfer_t  xstate;
    cehs_pkg::cehs_xfer_t  next_xstate;
    logic signed [15:0]    v_hold;
    logic signed [15:0]    i_hold;
    logic signed [31:0]    product;
    logic signed [31:0]    scaled;
    logic signed [31:0]    acc;
    logic signed [31:0]    acc_sum;
    logic [7:0]            sample_cnt;
    logic [7:0]            interval;
    logic                  interval_end;
    logic                  temp_phase;
    logic [15:0]           temp_prev;
    logic signed [48:0]    gain_prod;

    // zero in either field means no interval: accumulate, never transfer
    assign interval     = 8'(cfg.sum_cycles)
                          * 8'(cfg.pre_sample_count);
    assign acc_sum      = acc + scaled;
    assign interval_end = (interval != 8'h00)
                          && (sample_cnt + 8'h01 == interval);
    assign gain_prod    = product
                          * $signed({1'b0, cfg.temperature_gain_word});

    always_comb begin
        next_state = state;
        case (state)
            cehs_pkg::P_IDLE:  if (mux_start) next_state = cehs_pkg::P_MULT;
            cehs_pkg::P_MULT:  next_state = cehs_pkg::P_SCALE;
            cehs_pkg::P_SCALE: next_state = cehs_pkg::P_ACC;
            cehs_pkg::P_ACC:   next_state = cehs_pkg::P_IDLE;
            default:           next_state = cehs_pkg::P_IDLE;
        endcase
    end

    always_comb begin
        next_xstate = xstate;
        case (xstate)
            cehs_pkg::X_IDLE: begin
                if (state == cehs_pkg::P_ACC && interval_end) begin
                    next_xstate = cehs_pkg::X_POWER;
                end
            end
            cehs_pkg::X_POWER: next_xstate = cehs_pkg::X_TEMP;
            cehs_pkg::X_TEMP:  next_xstate = cehs_pkg::X_IDLE;
            default:           next_xstate = cehs_pkg::X_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= cehs_pkg::P_IDLE;
            xstate <= cehs_pkg::X_IDLE;
        end else begin
            state <= next_state;
            xstate <= next_xstate;
        end
    end

    // a start while a pass is running is ignored, one pulse per cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            processing_active <= 1'b0;
            irq_processing <= 1'b0;
        end else begin
            processing_active <= (next_state
                                  != cehs_pkg::P_IDLE);
            irq_processing <= processing_active
                              && (next_state == cehs_pkg::P_IDLE);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_transfer_flag <= 1'b0;
            irq_transfer <= 1'b0;
        end else begin
            result_transfer_flag <= (next_xstate
                                     != cehs_pkg::X_IDLE);
            irq_transfer <= result_transfer_flag
                            && (next_xstate == cehs_pkg::X_IDLE);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            v_hold <= 16'sh0000;
            i_hold <= 16'sh0000;
            product <= 32'sh00000000;
            scaled <= 32'sh00000000;
        end else begin
            if (state == cehs_pkg::P_IDLE && mux_start) begin
                v_hold <= volt_sample;
                i_hold <= curr_sample;
            end
            if (state == cehs_pkg::P_MULT) begin
                product <= v_hold * i_hold;
            end
            if (state == cehs_pkg::P_SCALE) begin
                scaled <= gain_prod[cehs_pkg::GAIN_SHIFT +: 32];
            end
        end
    end

    // clearing on the last pass frees the accumulator for the next interval
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc <= 32'sh00000000;
            sample_cnt <= 8'h00;
        end else if (state == cehs_pkg::P_ACC) begin
            if (interval_end) begin
                acc <= 32'sh00000000;
                sample_cnt <= 8'h00;
            end else begin
                acc <= acc_sum;
                sample_cnt <= sample_cnt + 8'h01;
            end
        end
    end

    // results go only to the shared RAM output area
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ram_wr <= '0;
        end else begin
            ram_wr.we <= (next_xstate != cehs_pkg::X_IDLE);
            ram_wr.addr <= (next_xstate == cehs_pkg::X_TEMP)
                           ? cehs_pkg::RES_ADDR_TEMP
                           : cehs_pkg::RES_ADDR_POWER;
            // the power word must include the closing pass, so it is
            // taken from the sum itself, not from a register behind it
            ram_wr.data <= (next_xstate == cehs_pkg::X_TEMP)
                           ? {15'h0000, temp_result} : acc_sum;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_phase <= 1'b0;
            temp_prev <= 16'h0000;
            temp_result <= 17'h00000;
        end else if (temp_valid) begin
            temp_phase <= !temp_phase;
            temp_prev <= temp_raw;
            if (temp_phase) begin
                temp_result <= {1'b0, temp_prev}
                               + {1'b0, temp_raw};
            end
        end
    end

    // assertion helper: passes finished since the last transfer
    logic [7:0] pass_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pass_cnt <= 8'h00;
        end else if (result_transfer_flag && !ram_wr.addr[0]
                     && irq_processing) begin
            pass_cnt <= 8'h00;
        end else if (irq_processing) begin
            pass_cnt <= pass_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_proc_pass;
        processing_active [*3] ##1 !processing_active;
    endsequence

    sequence s_xfer_pass;
        result_transfer_flag [*2] ##1 !result_transfer_flag;
    endsequence

    a_busy_per_start: assert property (
        (state == cehs_pkg::P_IDLE && mux_start) |=> s_proc_pass)
        else $error("processing flag not one three-cycle pulse");

    a_proc_irq_fall: assert property (
        $fell(processing_active) |-> irq_processing)
        else $error("no interrupt on processing fall");

    a_proc_irq_only: assert property (
        irq_processing |-> $fell(processing_active))
        else $error("processing interrupt without fall");

    a_xfer_irq_edge: assert property (
        ($fell(result_transfer_flag) |-> irq_transfer)
        and (irq_transfer |-> $fell(result_transfer_flag)))
        else $error("transfer interrupt not on falling edge");

    a_xfer_len: assert property (
        $rose(result_transfer_flag) |-> s_xfer_pass)
        else $error("transfer flag not a two-cycle level");

    a_xfer_writes: assert property (
        result_transfer_flag == ram_wr.we)
        else $error("transfer flag and RAM write disagree");

    a_xfer_interval: assert property (
        $rose(result_transfer_flag) |-> pass_cnt + 8'h01 == interval)
        else $error("transfer not at end of interval");

    a_temp_sum: assert property (
        (temp_valid && temp_phase) |=>
        temp_result == {1'b0, $past(temp_prev)} + {1'b0, $past(temp_raw)})
        else $error("temperature result not sum of pair");

endmodule : cehs_engine

`default_nettype wire

//--- testbench/cehs_host_model.sv
/* controller-side model: keeps the shared result RAM image and counts
 * interrupt pulses. assumes the engine's outputs on the same clock. */
`timescale 1ns/10ps
`default_nettype none

module cehs_host_model (
    input wire logic                   clk,            // system clock
    input wire logic                   resetn,         // async reset, low
    input wire logic                   irq_processing, // pass done
    input wire logic                   irq_transfer,   // results ready
    input wire cehs_pkg::cehs_ram_wr_t ram_wr          // result writes
);
    logic [31:0] ram [16];
    int          n_proc;
    int          n_xfer;

    // results reach the controller only through this shared image
    always_ff @(posedge clk) begin
        if (ram_wr.we) begin
            ram[ram_wr.addr] <= ram_wr.data;
        end
    end

    // the pulse already marks the falling edge, so count it once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            n_proc <= 0;
            n_xfer <= 0;
        end else begin
            n_proc <= n_proc + int'(irq_processing);
            n_xfer <= n_xfer + int'(irq_transfer);
        end
    end
endmodule : cehs_host_model

`default_nettype wire

//--- testbench/tb_compute_engine_host_signaling.sv
/* self-checking bench for the engine signalling block.
 * assumes the package and the engine and host model sources. */
`timescale 1ns/10ps
`default_nettype none

module tb_compute_engine_host_signaling;
    logic                   clk         = 1'b0;
    logic                   resetn      = 1'b0;
    cehs_pkg::cehs_cfg_t    cfg         = '0;
    logic                   mux_start   = 1'b0;
    logic signed [15:0]     volt_sample = '0;
    logic signed [15:0]     curr_sample = '0;
    logic                   temp_valid  = 1'b0;
    logic [15:0]            temp_raw    = '0;
    logic                   proc_act;
    logic                   xfer_flag;
    logic                   irq_proc;
    logic                   irq_xfer;
    cehs_pkg::cehs_ram_wr_t ram_wr;
    logic [16:0]            temp_result;
    logic [31:0]            acc         = '0;
    logic [16:0]            last_temp   = '0;
    int                     n_fail      = 0;
    int                     total_checks = 0;
    int                     cycles      = 0;
    int                     n_pass      = 0;
    int                     n_xfers     = 0;

    always #5 clk = ~clk;

    cehs_engine i_dut (
        .clk(clk), .resetn(resetn), .cfg(cfg), .mux_start(mux_start),
        .volt_sample(volt_sample), .curr_sample(curr_sample),
        .temp_valid(temp_valid), .temp_raw(temp_raw),
        .processing_active(proc_act), .result_transfer_flag(xfer_flag),
        .irq_processing(irq_proc), .irq_transfer(irq_xfer),
        .ram_wr(ram_wr), .temp_result(temp_result));

    cehs_host_model i_host (
        .clk(clk), .resetn(resetn), .irq_processing(irq_proc),
        .irq_transfer(irq_xfer), .ram_wr(ram_wr));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // per-sample scaling, truncated to the result word width
    function automatic logic [31:0] power(input logic signed [15:0] v,
                                          input logic signed [15:0] i,
                                          input logic [15:0] g);
        return 32'((longint'(v) * longint'(i) * longint'(g)) >>> 14);
    endfunction : power

    task automatic temp_pair(input logic [15:0] a, input logic [15:0] b);
        @(negedge clk);
        temp_valid = 1'b1;
        temp_raw = a;
        @(negedge clk);
        temp_raw = b;
        @(negedge clk);
        temp_valid = 1'b0;
        last_temp = {1'b0, a} + {1'b0, b};
        check(32'(temp_result), 32'(last_temp));
    endtask : temp_pair

    // poke retriggers mid-pass; the engine must ignore it
    task automatic run_pass(input logic xf, input logic poke);
        logic signed [15:0] v;
        logic signed [15:0] i;
        v = 16'($urandom_range(2047));
        i = 16'($urandom_range(2047));
        @(negedge clk);
        mux_start = 1'b1;
        volt_sample = v;
        curr_sample = i;
        acc = acc + power(v, i, cfg.temperature_gain_word);
        for (int k = 1; k <= 6; k++) begin
            @(negedge clk);
            mux_start = poke && (k == 2);
            volt_sample = 16'($urandom);
            check(32'(proc_act), 32'(k <= 3));
            check(32'(irq_proc), 32'(k == 4));
            check(32'(xfer_flag), 32'(xf && k inside {4, 5}));
            check(32'(ram_wr.we), 32'(xf && k inside {4, 5}));
            check(32'(irq_xfer), 32'(xf && k == 6));
            if (xf && k == 4) check(ram_wr.data, acc);
            if (xf && k == 5) check(ram_wr.data, 32'(last_temp));
        end
        n_pass++;
        if (xf) begin
            check(i_host.ram[0], acc);
            acc = '0;
            n_xfers++;
        end
    endtask : run_pass

    task automatic run_interval(input logic [5:0] sc, input logic [1:0] pre);
        int n;
        cfg.sum_cycles = sc;
        cfg.pre_sample_count = pre;
        cfg.temperature_gain_word = 16'($urandom_range(16395, 16375));
        n = int'(sc) * int'(pre);
        for (int p = 1; p <= n; p++) begin
            if ($urandom_range(1) == 1) temp_pair(16'($urandom), 16'($urandom));
            run_pass(p == n, p == 2);
        end
        $display("interval %0d x %0d done", sc, pre);
    endtask : run_interval

    // bounds a hang; the full run needs about 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("BAD t=%0t run timed out", $time);
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h3b0ca4c7));
        repeat (10) @(posedge clk);
        check(32'({proc_act, xfer_flag, irq_proc, irq_xfer}), 32'h0);
        check(32'({ram_wr.we, temp_result}), 32'h0);
        @(negedge clk);
        resetn = 1'b1;
        run_interval(6'h01, 2'h1);
        run_interval(6'h03, 2'h2);
        run_interval(6'h3f, 2'h3);
        repeat (4) run_interval(6'($urandom_range(5, 1)),
                                2'($urandom_range(3, 1)));
        // a zero product means no transfer ever comes
        cfg.pre_sample_count = 2'h0;
        repeat (3) run_pass(1'b0, 1'b0);
        $display("zero interval done");
        check(32'(i_host.n_proc), 32'(n_pass));
        check(32'(i_host.n_xfer), 32'(n_xfers));
        finish_test();
    end
endmodule : tb_compute_engine_host_signaling

`default_nettype wire
